// file: rtl/tdm_pkg.sv
// Contract
// - The mode byte holds, bit 7 down to 0: source address mode (2), destination address mode (2), transfer mode (2), repeat side select, size bit.
// - The mode byte has no reset value (the code resets its copy to zero); software fills each descriptor before it activates the controller for it.
// - Size bit 0 moves one byte per transfer, size bit 1 moves one 16-bit word.
// - Repeat side select 0 makes the destination the repeat or block area, 1 makes the source that area (the code uses it in block mode only).
// - Transfer mode 00 is normal, 01 is repeat and 10 is block transfer mode (the code runs 01 as normal mode).
// - Destination mode with upper bit 0 leaves the destination address unchanged after a transfer.
// - Destination mode 10 adds 1 (byte) or 2 (word) to the destination address after a transfer.
// - Destination mode 11 subtracts 1 (byte) or 2 (word) from the destination address after a transfer.
// - Source mode with upper bit 0 keeps the source address; mode 10 adds 1 (byte) or 2 (word) after a transfer.
// - Source mode 11 subtracts 1 (byte) or 2 (word) from the source address after a transfer.
// - Descriptor words are fetched from on-chip RAM as 32-bit accesses; all other accesses are 16 bits wide (the code's descriptor write-back is 32-bit too).
// - Descriptors live in a reserved window of on-chip RAM at fixed addresses.
// - A descriptor field gives the destination address to which each moved datum is written.
// - In block transfer mode a descriptor count holds the number of block transfers still to do.
package tdm_pkg;
    // ----------------------------------------
    // descriptor window and layout
    // ----------------------------------------
    localparam logic [15:0] DESC_BASE   = 16'hF800;
    localparam logic [15:0] DESC_LAST   = 16'hFBFF;
    localparam logic [15:0] DESC_STRIDE = 16'h0008;
    localparam logic [15:0] WORD1_OFS   = 16'h0004;
    localparam int          DESC_IDX_W  = 7;
    // word0: mode a, mode b, source address; word1: destination, count
    localparam int          W0_MODEA_LSB = 24;
    localparam int          W0_MODEB_LSB = 16;
    localparam int          W1_DST_LSB   = 16;

    // ----------------------------------------
    // mode byte fields
    // ----------------------------------------
    localparam int SRC_MODE_LSB = 6;
    localparam int DST_MODE_LSB = 4;
    localparam int XFER_MODE_LSB = 2;
    localparam int SIDE_SEL_BIT = 1;
    localparam int SIZE_BIT     = 0;

    localparam logic [1:0] AM_INC = 2'b10;
    localparam logic [1:0] AM_DEC = 2'b11;
    localparam logic [1:0] XM_NORMAL = 2'b00;
    localparam logic [1:0] XM_REPEAT = 2'b01;
    localparam logic [1:0] XM_BLOCK  = 2'b10;

    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;

    typedef enum logic [6:0] {
        ST_IDLE   = 7'b000_0001,
        ST_FETCH0 = 7'b000_0010,
        ST_FETCH1 = 7'b000_0100,
        ST_READ   = 7'b000_1000,
        ST_WRITE  = 7'b001_0000,
        ST_WB0    = 7'b010_0000,
        ST_WB1    = 7'b100_0000
    } tdm_state_t;
endpackage : tdm_pkg

// file: rtl/tdm_xfer_ctrl.sv
`timescale 1ns/10ps
module tdm_xfer_ctrl (
    // clock and reset
    input  wire logic                           core_clk_i,
    input  wire logic                           rst_i,
    // activation
    input  wire logic                           start_i,
    input  wire logic [tdm_pkg::DESC_IDX_W-1:0] desc_idx_i,
    output logic                                busy_o,
    output logic                                done_o,
    output logic                                count_zero_o,
    output logic                                window_err_o,
    // on-chip ram, 32-bit descriptor port
    output logic                                ram_req_o,
    output logic                                ram_we_o,
    output logic [15:0]                         ram_addr_o,
    output logic [31:0]                         ram_wdata_o,
    input  wire logic                           ram_ack_i,
    input  wire logic [31:0]                    ram_rdata_i,
    // data bus, 16-bit
    output logic                                bus_rd_req_o,
    output logic                                bus_wr_req_o,
    output logic                                bus_word_o,
    output logic [15:0]                         bus_addr_o,
    output logic [15:0]                         bus_wdata_o,
    input  wire logic                           bus_ack_i,
    input  wire logic [15:0]                    bus_rdata_i
);
    import tdm_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        tdm_state_t  st;
        logic [7:0]  mode_a;
        logic [7:0]  mode_b;
        logic [15:0] src;
        logic [15:0] dst;
        logic [15:0] cnt;
        logic [15:0] desc;
        logic        ram_req;
        logic        ram_we;
        logic [15:0] ram_addr;
        logic [31:0] ram_wdata;
        logic        rd_req;
        logic        wr_req;
        logic        word;
        logic [15:0] bus_addr;
        logic [15:0] wdata;
        logic [1:0][15:0] fifo;
        logic [1:0]  fill;
        logic        rd_ptr;
        logic        wr_ptr;
        logic        busy;
        logic        done;
        logic        cnt_zero;
        logic        err;
    } tdm_regs_t;

    tdm_regs_t s_q, s_d;

    // address update after a transfer
    function automatic logic [15:0] tdm_step(input logic [1:0]  am,
                                             input logic [15:0] a,
                                             input logic        sz);
        logic [15:0] d;
        d = sz ? STEP_WORD : STEP_BYTE;
        if (am == AM_INC)
            tdm_step = a + d;
        else if (am == AM_DEC)
            tdm_step = a - d;
        else
            tdm_step = a;
    endfunction : tdm_step

    logic [1:0]  src_am, dst_am, xm;
    logic        side_src, size_w, area_held;
    logic        fifo_full, fifo_empty;
    logic [15:0] desc_addr;

    assign src_am   = s_q.mode_a[SRC_MODE_LSB +: 2];
    assign dst_am   = s_q.mode_a[DST_MODE_LSB +: 2];
    assign xm       = s_q.mode_a[XFER_MODE_LSB +: 2];
    assign side_src = s_q.mode_a[SIDE_SEL_BIT];
    assign size_w   = s_q.mode_a[SIZE_BIT];
    // block area side is held unchanged after each transfer; code 11 is taken as normal
    assign area_held = (xm == XM_BLOCK);
    assign fifo_full  = (s_q.fill == 2'd2);
    assign fifo_empty = (s_q.fill == 2'd0);
    assign desc_addr  = DESC_BASE + 16'(desc_idx_i) * DESC_STRIDE;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        case (s_q.st)
            ST_IDLE: begin
                if (start_i) begin
                    // mode byte resets to zero; it is loaded only from ram
                    s_d.desc     = desc_addr;
                    s_d.err      = (desc_addr > DESC_LAST);
                    if (desc_addr <= DESC_LAST) begin
                        s_d.busy     = 1'b1;
                        s_d.ram_req  = 1'b1;
                        s_d.ram_we   = 1'b0;
                        s_d.ram_addr = desc_addr;
                        s_d.st       = ST_FETCH0;
                    end
                end
            end
            ST_FETCH0: begin
                if (ram_ack_i) begin
                    s_d.mode_a   = ram_rdata_i[W0_MODEA_LSB +: 8];
                    s_d.mode_b   = ram_rdata_i[W0_MODEB_LSB +: 8];
                    s_d.src      = ram_rdata_i[15:0];
                    s_d.ram_addr = s_q.desc + WORD1_OFS;
                    s_d.st       = ST_FETCH1;
                end
            end
            ST_FETCH1: begin
                if (ram_ack_i) begin
                    s_d.dst     = ram_rdata_i[W1_DST_LSB +: 16];
                    s_d.cnt     = ram_rdata_i[15:0];
                    s_d.ram_req = 1'b0;
                    s_d.st      = ST_READ;
                end
            end
            ST_READ: begin
                // read only while the buffer can take the word
                if (!s_q.rd_req && !fifo_full) begin
                    s_d.rd_req   = 1'b1;
                    s_d.word     = size_w;
                    s_d.bus_addr = s_q.src;
                end else if (s_q.rd_req && bus_ack_i) begin
                    s_d.rd_req             = 1'b0;
                    s_d.fifo[s_q.wr_ptr]   = size_w ? bus_rdata_i
                                                    : {8'h00, bus_rdata_i[7:0]};
                    s_d.wr_ptr             = ~s_q.wr_ptr;
                    s_d.fill               = s_q.fill + 2'd1;
                    s_d.st                 = ST_WRITE;
                end
            end
            ST_WRITE: begin
                if (!s_q.wr_req && !fifo_empty) begin
                    s_d.wr_req   = 1'b1;
                    s_d.bus_addr = s_q.dst;
                    s_d.wdata    = s_q.fifo[s_q.rd_ptr];
                end else if (s_q.wr_req && bus_ack_i) begin
                    s_d.wr_req = 1'b0;
                    s_d.rd_ptr = ~s_q.rd_ptr;
                    s_d.fill   = s_q.fill - 2'd1;
                    // block area side is the one kept in place
                    s_d.src = (area_held && side_src) ? s_q.src
                                                      : tdm_step(src_am, s_q.src, size_w);
                    s_d.dst = (area_held && !side_src) ? s_q.dst
                                                       : tdm_step(dst_am, s_q.dst, size_w);
                    s_d.cnt = s_q.cnt - 16'h0001;
                    s_d.st  = ST_WB0;
                end
            end
            ST_WB0: begin
                if (!s_q.ram_req) begin
                    s_d.ram_req   = 1'b1;
                    s_d.ram_we    = 1'b1;
                    s_d.ram_addr  = s_q.desc;
                    s_d.ram_wdata = {s_q.mode_a, s_q.mode_b, s_q.src};
                end else if (ram_ack_i) begin
                    s_d.ram_addr  = s_q.desc + WORD1_OFS;
                    s_d.ram_wdata = {s_q.dst, s_q.cnt};
                    s_d.st        = ST_WB1;
                end
            end
            ST_WB1: begin
                if (ram_ack_i) begin
                    s_d.ram_req  = 1'b0;
                    s_d.ram_we   = 1'b0;
                    s_d.busy     = 1'b0;
                    s_d.done     = 1'b1;
                    s_d.cnt_zero = (s_q.cnt == 16'h0000);
                    s_d.st       = ST_IDLE;
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            s_q      <= '0;
            s_q.st   <= ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign busy_o       = s_q.busy;
    assign done_o       = s_q.done;
    assign count_zero_o = s_q.cnt_zero;
    assign window_err_o = s_q.err;
    assign ram_req_o    = s_q.ram_req;
    assign ram_we_o     = s_q.ram_we;
    assign ram_addr_o   = s_q.ram_addr;
    assign ram_wdata_o  = s_q.ram_wdata;
    assign bus_rd_req_o = s_q.rd_req;
    assign bus_wr_req_o = s_q.wr_req;
    assign bus_word_o   = s_q.word;
    assign bus_addr_o   = s_q.bus_addr;
    assign bus_wdata_o  = s_q.wdata;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic wr_done;
    assign wr_done = (s_q.st == ST_WRITE) && s_q.wr_req && bus_ack_i;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    ram_in_window_a: assert property (ram_req_o |-> (ram_addr_o >= DESC_BASE)
        && (ram_addr_o <= DESC_LAST)) else $error("descriptor access outside window");
    fetch_is_read_a: assert property ((s_q.st == ST_FETCH0 || s_q.st == ST_FETCH1)
        && ram_req_o |-> !ram_we_o) else $error("descriptor fetch not a read");
    size_follows_a: assert property ((bus_rd_req_o || bus_wr_req_o) |->
        bus_word_o == size_w) else $error("transfer width differs from size bit");
    dst_target_a: assert property (bus_wr_req_o |-> bus_addr_o == s_q.dst)
        else $error("write not aimed at destination address");
    dst_inc_a: assert property (wr_done && dst_am == AM_INC && !area_held |=>
        s_q.dst == $past(s_q.dst) + (size_w ? STEP_WORD : STEP_BYTE))
        else $error("destination not incremented");
    dst_dec_a: assert property (wr_done && dst_am == AM_DEC && !area_held |=>
        s_q.dst == $past(s_q.dst) - (size_w ? STEP_WORD : STEP_BYTE))
        else $error("destination not decremented");
    dst_fixed_a: assert property (wr_done && !dst_am[1] |=> $stable(s_q.dst))
        else $error("fixed destination moved");
    src_step_a: assert property (wr_done && src_am == AM_INC && !area_held |=>
        s_q.src == $past(s_q.src) + (size_w ? STEP_WORD : STEP_BYTE))
        else $error("source not incremented");
    src_dec_a: assert property (wr_done && src_am == AM_DEC && !area_held |=>
        s_q.src == $past(s_q.src) - (size_w ? STEP_WORD : STEP_BYTE))
        else $error("source not decremented");
    desc_writeback_a: assert property (wr_done |=> ##1 (ram_req_o && ram_we_o
        && ram_wdata_o[15:0] == s_q.src)) else $error("source not written back");
endmodule : tdm_xfer_ctrl

// file: sim/tdm_far_model.sv
`timescale 1ns/10ps
module tdm_far_model
    import tdm_pkg::*;
(
    // clock, reset, pacing
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        slow_i,
    // descriptor ram
    input  wire logic        ram_req_i,
    input  wire logic        ram_we_i,
    input  wire logic [15:0] ram_addr_i,
    input  wire logic [31:0] ram_wdata_i,
    output logic             ram_ack_o,
    output logic [31:0]      ram_rdata_o,
    // data bus target
    input  wire logic        rd_req_i,
    input  wire logic        wr_req_i,
    input  wire logic        word_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [15:0] wdata_i,
    output logic             bus_ack_o,
    output logic [15:0]      bus_rdata_o
);
    logic [31:0] mem [0:255];
    logic [15:0] rd_addr, wr_addr, wr_data;
    logic        rd_word, wr_word;
    logic [1:0]  rc, bc;
    int          nrd;
    // ----------------------------------------
    // ram: one 32-bit word per access, 1 kbyte window
    // ----------------------------------------
    // plain always: the bench preloads mem from outside this process
    always @(posedge clk_i) begin
        ram_ack_o <= 1'b0;
        // released lines toggle so a stale word never looks valid
        ram_rdata_o <= ~ram_rdata_o;
        if (rst_i) begin
            rc <= 2'd0;
        end else if (ram_ack_o) begin
            rc <= 2'd0;
        end else if (ram_req_i && rc == (slow_i ? 2'd2 : 2'd0)) begin
            ram_ack_o <= 1'b1;
            ram_rdata_o <= mem[ram_addr_i[9:2]];
            if (ram_we_i) begin
                mem[ram_addr_i[9:2]] <= ram_wdata_i;
            end
        end else if (ram_req_i) begin
            rc <= rc + 2'd1;
        end
    end
    // ----------------------------------------
    // data bus: read data is a pattern of the address
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        bus_ack_o <= 1'b0;
        bus_rdata_o <= ~bus_rdata_o;
        if (rst_i) begin
            bc <= 2'd0;
            nrd <= 0;
        end else if (bus_ack_o) begin
            bc <= 2'd0;
        end else if ((rd_req_i || wr_req_i) && bc == (slow_i ? 2'd2 : 2'd0)) begin
            bus_ack_o <= 1'b1;
            if (rd_req_i) begin
                bus_rdata_o <= addr_i ^ 16'hA5C3;
                rd_addr <= addr_i;
                rd_word <= word_i;
                nrd <= nrd + 1;
            end else begin
                wr_addr <= addr_i;
                wr_data <= wdata_i;
                wr_word <= word_i;
            end
        end else if (rd_req_i || wr_req_i) begin
            bc <= bc + 2'd1;
        end
    end
endmodule : tdm_far_model

// file: sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import tdm_pkg::*;
    logic                  core_clk_i, rst_i, start_i, slow;
    logic [DESC_IDX_W-1:0] desc_idx_i;
    logic                  busy_o, done_o, count_zero_o, window_err_o;
    logic                  ram_req_o, ram_we_o, ram_ack_i;
    logic [15:0]           ram_addr_o, bus_addr_o, bus_wdata_o, bus_rdata_i;
    logic [31:0]           ram_wdata_o, ram_rdata_i;
    logic                  bus_rd_req_o, bus_wr_req_o, bus_word_o, bus_ack_i;
    int                    error_cnt, samples_checked, n;

    tdm_xfer_ctrl i_tdm_xfer_ctrl (.core_clk_i(core_clk_i), .rst_i(rst_i), .start_i(start_i),
        .desc_idx_i(desc_idx_i), .busy_o(busy_o), .done_o(done_o), .count_zero_o(count_zero_o),
        .window_err_o(window_err_o), .ram_req_o(ram_req_o), .ram_we_o(ram_we_o),
        .ram_addr_o(ram_addr_o), .ram_wdata_o(ram_wdata_o), .ram_ack_i(ram_ack_i),
        .ram_rdata_i(ram_rdata_i), .bus_rd_req_o(bus_rd_req_o), .bus_wr_req_o(bus_wr_req_o),
        .bus_word_o(bus_word_o), .bus_addr_o(bus_addr_o), .bus_wdata_o(bus_wdata_o),
        .bus_ack_i(bus_ack_i), .bus_rdata_i(bus_rdata_i));
    tdm_far_model i_far (.clk_i(core_clk_i), .rst_i(rst_i), .slow_i(slow),
        .ram_req_i(ram_req_o), .ram_we_i(ram_we_o), .ram_addr_i(ram_addr_o),
        .ram_wdata_i(ram_wdata_o), .ram_ack_o(ram_ack_i), .ram_rdata_o(ram_rdata_i),
        .rd_req_i(bus_rd_req_o), .wr_req_i(bus_wr_req_o), .word_i(bus_word_o),
        .addr_i(bus_addr_o), .wdata_i(bus_wdata_o), .bus_ack_o(bus_ack_i),
        .bus_rdata_o(bus_rdata_i));

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic conclude();
        if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    // ----------------------------------------
    // one activation: load descriptor, start, wait, compare
    // ----------------------------------------
    task automatic run(input logic [6:0] v, input logic rst_mid);
        logic [7:0]  md;
        logic [1:0]  xm;
        logic [15:0] src, dst, st, ns, nd, pat;
        int          k, r0;
        xm = 2'(v % 3); // code 11 never programmed
        md = {v[1:0], v[3:2], xm, v[4], v[5]};
        src = 16'(v * 16'h0411);
        dst = 16'h8000 ^ 16'(v * 7);
        i_far.mem[2*v] = {md, 8'h5A, src};
        i_far.mem[2*v+1] = {dst, 9'h000, v};
        r0 = i_far.nrd;
        @(posedge core_clk_i);
        start_i <= 1'b1;
        desc_idx_i <= v;
        slow <= v[0];
        @(posedge core_clk_i);
        start_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        // a second start while busy must be dropped
        start_i <= v[2];
        desc_idx_i <= ~v;
        chk("busy", busy_o, 1'b1);
        @(posedge core_clk_i);
        start_i <= 1'b0;
        if (rst_mid) begin
            rst_i <= 1'b1;
            repeat (2) @(posedge core_clk_i);
            rst_i <= 1'b0;
            chk("rst_outs", {busy_o, done_o, ram_req_o, bus_rd_req_o, bus_wr_req_o}, 5'h00);
            return;
        end
        for (k = 0; k < 200 && done_o !== 1'b1; k++) @(posedge core_clk_i);
        chk("done", done_o, 1'b1);
        st = md[0] ? STEP_WORD : STEP_BYTE;
        ns = !md[7] ? src : md[6] ? src - st : src + st;
        nd = !md[5] ? dst : md[4] ? dst - st : dst + st;
        if (xm == XM_BLOCK && md[1]) ns = src;
        if (xm == XM_BLOCK && !md[1]) nd = dst;
        pat = src ^ 16'hA5C3;
        chk("rd_addr", i_far.rd_addr, src);
        chk("rd_word", i_far.rd_word, md[0]);
        chk("wr_word", i_far.wr_word, md[0]);
        chk("wr_addr", i_far.wr_addr, dst);
        chk("wr_data", i_far.wr_data & (md[0] ? 16'hFFFF : 16'h00FF),
            md[0] ? pat : {8'h00, pat[7:0]});
        chk("reads", 32'(i_far.nrd - r0), 32'd1);
        chk("wb0", i_far.mem[2*v], {md, 8'h5A, ns});
        chk("wb1", i_far.mem[2*v+1], {nd, 16'({9'h000, v}) - 16'h0001});
        chk("cnt_zero", count_zero_o, v == 7'd1);
        chk("win_err", window_err_o, 1'b0);
    endtask : run

    initial begin
        rst_i = 1'b1;
        start_i = 1'b0;
        slow = 1'b0;
        desc_idx_i = '0;
        error_cnt = 0;
        samples_checked = 0;
        repeat (5) @(posedge core_clk_i);
        rst_i <= 1'b0;
        for (n = 0; n < 64; n++) run(7'(n), 1'b0);
        run(7'd127, 1'b1);
        run(7'd126, 1'b0);
        conclude();
    end
    initial begin
        repeat (20000) @(posedge core_clk_i);
        error_cnt++;
        conclude();
    end
endmodule : tb_top
